// [pkg/dcf_consts.svh]
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH
// Frame layout
`define DCF_FRAME_BITS   6'h20
`define DCF_FRAME_W      32
`define DCF_DATA_W       24
// Message identifiers
`define DCF_ID_CFG_HI    7'h03
`define DCF_ID_FAULT_LO  7'h04
// Reset values
`define DCF_THR_RESET    2'h3
`define DCF_RETRY_RESET  4'hf
`define DCF_CFG_RESET    24'hff_ffff
`define DCF_FLAG_RESET   24'h00_0000
// Retry period is the field times sixteen PWM periods
`define DCF_RETRY_SHIFT  4
`endif

// [pkg/dcf_pkg.sv]
package dcf_pkg;
   typedef enum logic [0:0]
   {
      DCF_IDLE  = 1'b0,
      DCF_SHIFT = 1'b1
   } dcf_state_e;

   typedef struct packed
   {
      logic       wr;
      logic [6:0] id;
      logic [23:0] data;
   } dcf_frame_s;

   typedef struct packed
   {
      logic [1:0] thr;
      logic [3:0] retry;
   } dcf_chan_s;

   typedef struct packed
   {
      logic gnd;
      logic off_tst;
      logic batt;
      logic batt_tst;
      logic ol_off;
      logic ol_on;
   } dcf_flags_s;
endpackage : dcf_pkg

// [rtl/dcf_diag_regs.sv]
// Functional notes
// - Bits 30:24 identify message; bit 31 write.
// - Threshold codes at 23:22,17:16,11:10,5:4.
// - Threshold code picks comparator level; resets 11.
// - Retry fields at 21:18,15:12,9:6,3:0.
// - Retry after sixteen times field; reset 1111b.
// - Settings reply: 0, identifier, stored fields.
// - Fault message write acts as read.
// - Fault reply: 0, identifier, channel 0 highest.
// - Ground-short flags at 23,17,11,5.
// - Off-state test done at 22,16,10,4.
// - Battery-short flags at 21,15,9,3.
// - Battery-short test done at 20,14,8,2.
// - Gate-off open load at 19,13,7,1.
// - Gate-on open load at 18,12,6,0.
`include "dcf_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module dcf_diag_regs
(
   // System
   input  wire logic        CLOCK,
   input  wire logic        RESETN,
   // Serial link, mode 0
   input  wire logic        SPI_SCLK,
   input  wire logic        SPI_CSN,
   input  wire logic        SPI_MOSI,
   output var  logic        SPI_MISO,
   output var  logic        SPI_MISO_OE,
   // Fault events of channels 0 to 3, bit i is channel i
   input  wire logic [3:0]  GROUND_SHORT_FAULT,
   input  wire logic [3:0]  OFF_STATE_TEST_DONE,
   input  wire logic [3:0]  BATTERY_SHORT_FAULT,
   input  wire logic [3:0]  BATTERY_SHORT_TEST_DONE,
   input  wire logic [3:0]  OPEN_LOAD_GATE_OFF_FAULT,
   input  wire logic [3:0]  OPEN_LOAD_GATE_ON_FAULT,
   // Settings of channels 4 to 7, channel 4 in the top slice
   output var  logic [7:0]  BATTERY_SHORT_THRESHOLD_OR_FAULT,
   output var  logic [15:0] BATTERY_SHORT_RETRY_COUNT,
   output var  logic [31:0] RETRY_PERIODS
);

   logic [2:0]                sclk_q;
   logic [1:0]                csn_q;
   logic [1:0]                mosi_q;
   dcf_pkg::dcf_flags_s [3:0] ev_raw;
   logic [23:0]               ev1_q;
   logic [23:0]               ev2_q;
   logic                      sclk_rise;
   logic                      sclk_fall;
   logic                      csn_low;

   dcf_pkg::dcf_state_e       state_q;
   dcf_pkg::dcf_state_e       state_d;
   logic [5:0]                cnt_q;
   logic [5:0]                cnt_d;
   logic [31:0]               rx_q;
   logic [31:0]               rx_d;
   logic [31:0]               tx_q;
   logic [31:0]               tx_d;
   logic                      miso_q;
   logic                      miso_d;
   logic                      oe_q;
   logic                      oe_d;
   logic                      done;
   dcf_pkg::dcf_frame_s       req;
   dcf_pkg::dcf_frame_s       reply;

   dcf_pkg::dcf_chan_s [3:0]  settings_q;
   dcf_pkg::dcf_chan_s [3:0]  settings_d;
   logic [23:0]               flags_q;
   logic [23:0]               flags_d;
   logic                      clr;
   logic [7:0]                thr_q;
   logic [7:0]                thr_d;
   logic [15:0]               retry_q;
   logic [15:0]               retry_d;
   logic [31:0]               per_q;
   logic [31:0]               per_d;

   // Channel 0 lands in the top group of the reply
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         ev_raw[3-i].gnd      = GROUND_SHORT_FAULT[i];
         ev_raw[3-i].off_tst  = OFF_STATE_TEST_DONE[i];
         ev_raw[3-i].batt     = BATTERY_SHORT_FAULT[i];
         ev_raw[3-i].batt_tst = BATTERY_SHORT_TEST_DONE[i];
         ev_raw[3-i].ol_off   = OPEN_LOAD_GATE_OFF_FAULT[i];
         ev_raw[3-i].ol_on    = OPEN_LOAD_GATE_ON_FAULT[i];
      end
   end

   // Pins are asynchronous; SCLK must stay below a sixth of CLOCK
   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sclk_q <= 3'h0;
         csn_q  <= 2'h3;
         mosi_q <= 2'h0;
         ev1_q  <= 24'h00_0000;
         ev2_q  <= 24'h00_0000;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], SPI_SCLK};
         csn_q  <= {csn_q[0], SPI_CSN};
         mosi_q <= {mosi_q[0], SPI_MOSI};
         ev1_q  <= ev_raw;
         ev2_q  <= ev1_q;
      end
   end

   assign sclk_rise = sclk_q[1] & ~sclk_q[2];
   assign sclk_fall = ~sclk_q[1] & sclk_q[2];
   assign csn_low   = ~csn_q[1];
   assign req       = rx_q;

   // Frame engine; the reply goes out during the next frame
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      rx_d    = rx_q;
      tx_d    = tx_q;
      miso_d  = miso_q;
      oe_d    = csn_low;
      done    = 1'b0;
      case (state_q)
         dcf_pkg::DCF_IDLE:
         begin
            miso_d = tx_q[31];
            if (csn_low)
            begin
               state_d = dcf_pkg::DCF_SHIFT;
               cnt_d   = 6'h00;
            end
         end
         dcf_pkg::DCF_SHIFT:
         begin
            if (!csn_low)
            begin
               state_d = dcf_pkg::DCF_IDLE;
               // Short or long frames are dropped whole
               done    = (cnt_q == `DCF_FRAME_BITS);
            end
            else
            begin
               if (sclk_rise)
               begin
                  rx_d = {rx_q[30:0], mosi_q[1]};
                  if (cnt_q != `DCF_FRAME_BITS + 6'h01)
                  begin
                     cnt_d = cnt_q + 6'h01;
                  end
               end
               if (sclk_fall)
               begin
                  tx_d   = {tx_q[30:0], 1'b0};
                  miso_d = tx_q[30];
               end
            end
         end
         default:
         begin
            state_d = dcf_pkg::DCF_IDLE;
         end
      endcase
      if (done)
      begin
         tx_d = reply;
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state_q <= dcf_pkg::DCF_IDLE;
         cnt_q   <= 6'h00;
         rx_q    <= 32'h0000_0000;
         tx_q    <= 32'h0000_0000;
         miso_q  <= 1'b0;
         oe_q    <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         rx_q    <= rx_d;
         tx_q    <= tx_d;
         miso_q  <= miso_d;
         oe_q    <= oe_d;
      end
   end

   // Message decode, settings store and sticky fault flags
   always_comb
   begin
      settings_d = settings_q;
      clr        = 1'b0;
      reply.wr   = 1'b0;
      reply.id   = req.id;
      reply.data = `DCF_FLAG_RESET;
      if (done)
      begin
         case (req.id)
            `DCF_ID_CFG_HI:
            begin
               if (req.wr)
               begin
                  settings_d = req.data;
               end
               reply.data = settings_d;
            end
            `DCF_ID_FAULT_LO:
            begin
               // Write bit ignored, nothing stored
               reply.data = flags_q | ev2_q;
               clr        = 1'b1;
            end
            default:
            begin
               reply.data = `DCF_FLAG_RESET;
            end
         endcase
      end
      // A new event wins over the clear on read
      flags_d = (clr ? `DCF_FLAG_RESET : flags_q) | ev2_q;
      for (int i = 0; i < 4; i++)
      begin
         thr_d[2*i +: 2]   = settings_q[i].thr;
         retry_d[4*i +: 4] = settings_q[i].retry;
         per_d[8*i +: 8]   = {settings_q[i].retry, 4'h0};
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         settings_q <= `DCF_CFG_RESET;
         flags_q    <= `DCF_FLAG_RESET;
         thr_q      <= {4{`DCF_THR_RESET}};
         retry_q    <= {4{`DCF_RETRY_RESET}};
         per_q      <= {4{`DCF_RETRY_RESET, 4'h0}};
      end
      else
      begin
         settings_q <= settings_d;
         flags_q    <= flags_d;
         thr_q      <= thr_d;
         retry_q    <= retry_d;
         per_q      <= per_d;
      end
   end

   assign SPI_MISO                         = miso_q;
   assign SPI_MISO_OE                      = oe_q;
   assign BATTERY_SHORT_THRESHOLD_OR_FAULT = thr_q;
   assign BATTERY_SHORT_RETRY_COUNT        = retry_q;
   assign RETRY_PERIODS                    = per_q;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESETN);

   sequence cfg_frame_s;
      done && req.id == `DCF_ID_CFG_HI;
   endsequence

   sequence fault_frame_s;
      done && req.id == `DCF_ID_FAULT_LO;
   endsequence

   sequence out_edge_s;
      state_q == dcf_pkg::DCF_SHIFT && csn_low && sclk_fall;
   endsequence

   id_echo_a : assert property (
      done |=> tx_q[30:24] == $past(req.id) && !tx_q[31])
      else $error("reply identifier not echoed");

   cfg_write_a : assert property (
      cfg_frame_s and req.wr |=> settings_q == $past(rx_q[23:0]))
      else $error("settings write not stored");

   cfg_hold_a : assert property (
      !(done && req.wr && req.id == `DCF_ID_CFG_HI) |=>
         settings_q == $past(settings_q))
      else $error("settings changed without full write frame");

   thr_out_a : assert property (
      ##1 thr_q[7:6] == $past(settings_q[3].thr))
      else $error("channel 4 threshold output wrong");

   retry_per_a : assert property (
      ##1 per_q[31:24] == {$past(settings_q[3].retry), 4'h0})
      else $error("channel 4 retry period not sixteen times field");

   cfg_reply_a : assert property (
      cfg_frame_s |=> tx_q[23:0] == settings_q)
      else $error("settings reply does not show stored fields");

   fault_ro_a : assert property (
      fault_frame_s |=> settings_q == $past(settings_q))
      else $error("fault read altered settings");

   fault_reply_a : assert property (
      fault_frame_s |=> tx_q[23:0] == $past(flags_q | ev2_q))
      else $error("fault reply does not carry flags");

   set_wins_a : assert property (
      ev2_q != 24'h00_0000 |=> (flags_q & $past(ev2_q)) == $past(ev2_q))
      else $error("fault event lost");

   shift_out_a : assert property (
      out_edge_s |=> SPI_MISO == $past(tx_q[30]) && SPI_MISO_OE)
      else $error("reply bit not shifted out");

endmodule : dcf_diag_regs

`default_nettype wire

// [tb/dcf_host.sv]
`timescale 1ns/10ps
`default_nettype none
module dcf_host
(
   // Clock
   input  wire logic CLOCK,
   // Serial link
   output var  logic SCLK,
   output var  logic CSN,
   output var  logic MOSI,
   input  wire logic MISO
);
   initial
   begin
      SCLK = 1'b0;
      CSN  = 1'b1;
      MOSI = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask : cyc
   // Five-cycle phases leave margin over the three-cycle minimum
   task automatic xfer(input logic [31:0] tx, input int nbits,
                       output logic [31:0] rx);
      rx = 32'h0000_0000;
      cyc(1);
      CSN = 1'b0;
      cyc(4);
      for (int i = 31; i > 31 - nbits; i--)
      begin
         MOSI = tx[i];
         cyc(5);
         rx[i] = MISO;
         SCLK = 1'b1;
         cyc(5);
         SCLK = 1'b0;
      end
      cyc(5);
      CSN  = 1'b1;
      MOSI = ~MOSI;
      cyc(8);
   endtask : xfer
endmodule : dcf_host
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clock;
   logic        resetn;
   logic        sclk;
   logic        csn;
   logic        mosi;
   logic        miso;
   logic        miso_oe;
   logic        miso_bus;
   logic [3:0]  ev [6];
   logic [7:0]  thr;
   logic [15:0] retry;
   logic [31:0] periods;
   logic [31:0] rx;
   int          miscompares;
   int          n_checks;

   dcf_host dcf_host_i
   (
      .CLOCK (clock),
      .SCLK  (sclk),
      .CSN   (csn),
      .MOSI  (mosi),
      .MISO  (miso_bus)
   );
   // Released line reads inverted, so a late enable spoils the sample
   assign miso_bus = miso_oe ? miso : ~miso;
   dcf_diag_regs dcf_diag_regs_i
   (
      .CLOCK                            (clock),
      .RESETN                           (resetn),
      .SPI_SCLK                         (sclk),
      .SPI_CSN                          (csn),
      .SPI_MOSI                         (mosi),
      .SPI_MISO                         (miso),
      .SPI_MISO_OE                      (miso_oe),
      .GROUND_SHORT_FAULT               (ev[0]),
      .OFF_STATE_TEST_DONE              (ev[1]),
      .BATTERY_SHORT_FAULT              (ev[2]),
      .BATTERY_SHORT_TEST_DONE          (ev[3]),
      .OPEN_LOAD_GATE_OFF_FAULT         (ev[4]),
      .OPEN_LOAD_GATE_ON_FAULT          (ev[5]),
      .BATTERY_SHORT_THRESHOLD_OR_FAULT (thr),
      .BATTERY_SHORT_RETRY_COUNT        (retry),
      .RETRY_PERIODS                    (periods)
   );

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   task automatic t_reset();
      chk("thr", 32'h0000_00ff, {24'h00_0000, thr});
      chk("retry", 32'h0000_ffff, {16'h0000, retry});
      chk("periods", 32'hf0f0_f0f0, periods);
      chk("oe idle", 32'h0000_0000, {31'h0000_0000, miso_oe});
      dcf_host_i.xfer(32'h0400_0000, 32, rx);
      dcf_host_i.xfer(32'h0300_0000, 32, rx);
      chk("fault reset", 32'h0400_0000, rx);
   endtask : t_reset

   // Retry field 0 on the last channel hits the low boundary
   task automatic t_write();
      dcf_host_i.xfer(32'h8305_5ab0, 32, rx);
      chk("cfg reset", 32'h03ff_ffff, rx);
      chk("thr", 32'h0000_001b, {24'h00_0000, thr});
      chk("retry", 32'h0000_15a0, {16'h0000, retry});
      chk("periods", 32'h1050_a000, periods);
      dcf_host_i.xfer(32'h8300_0000, 31, rx);
      chk("cfg reply", 32'h0305_5ab0, rx);
      chk("short frame", 32'h0000_001b, {24'h00_0000, thr});
   endtask : t_write

   task automatic t_fault();
      logic [23:0] e;
      e = 24'h00_0000;
      for (int k = 0; k < 6; k++)
      begin
         ev[k][k % 4] = 1'b1;
         e[23 - 6 * (k % 4) - k] = 1'b1;
      end
      repeat (2) @(posedge clock);
      #1;
      foreach (ev[k]) ev[k] = 4'h0;
      dcf_host_i.xfer(32'h8400_0000, 32, rx);
      dcf_host_i.xfer(32'h0300_0000, 32, rx);
      chk("flags", {8'h04, e}, rx);
      chk("fault write", 32'h1050_a000, periods);
      dcf_host_i.xfer(32'hff12_3456, 32, rx);
      chk("cfg read", 32'h0305_5ab0, rx);
      dcf_host_i.xfer(32'h0400_0000, 32, rx);
      chk("unknown id", 32'h7f00_0000, rx);
      dcf_host_i.xfer(32'h0300_0000, 32, rx);
      chk("flags cleared", 32'h0400_0000, rx);
      chk("unknown write", 32'h0000_001b, {24'h00_0000, thr});
   endtask : t_fault

   // Second reset in mid-run must restore the output, settings and reply reset values
   task automatic t_rerst();
      resetn = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      resetn = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      chk("rst thr", 32'h0000_00ff, {24'h00_0000, thr});
      chk("rst retry", 32'h0000_ffff, {16'h0000, retry});
      chk("rst periods", 32'hf0f0_f0f0, periods);
      chk("rst oe", 32'h0000_0000, {31'h0000_0000, miso_oe});
      dcf_host_i.xfer(32'h0300_0000, 32, rx);
      chk("rst reply", 32'h0000_0000, rx);
      dcf_host_i.xfer(32'h0000_0000, 32, rx);
      chk("rst cfg", 32'h03ff_ffff, rx);
   endtask : t_rerst

   initial
   begin
      foreach (ev[k]) ev[k] = 4'h0;
      resetn      = 1'b0;
      miscompares = 0;
      n_checks    = 0;
      repeat (10) @(posedge clock);
      #1;
      resetn = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      t_reset();
      t_write();
      t_fault();
      t_rerst();
      close_out();
   end
endmodule : tb_top
`default_nettype wire
